// ===== core/bri_banked_request.sv
// three cascaded request banks: capture, host signalling, acknowledge and end of service
// assumes inputs synchronous to i_clk, a host bus that presents status on i_cycle_start
//
// What this block does
// - external requests active low, edge or level
// - shared pin ORs request with timer two output
// - internal sources sit at fixed levels
// - timer requests latch on rising timer edge
// - timer latch clears on acknowledge, mask, reset
// - chaining and terminal count feed their levels
// - init word two write requests, readback clears
// - level 1.5 ORs bank B, wins over it
// - nothing pending gives bank A level 7 vector
// - host request high while any unmasked pending not inhibited by in-service
// - acknowledge recognised by three status lines low
// - first cycle resolves, drives 00H without slave
// - second cycle drives selected level's vector
// - slave present, bank C level 2 excepted: vector first, float second
// - host idles between; device adds wait states
// - each bank programmed independently, any time
// - non-specific end clears highest in-service bit
// - specific end clears the named level
// - automatic mode ends service after second cycle
// - level 0 highest; in-service inhibits same, lower
// - mask bit disables only its own level
//
// Implementation choices: the placing of the registers and the plain strobed port.
`default_nettype none
`include "bri_regs.svh"

module bri_banked_request
  import bri_pkg::*;
#(
  parameter logic [3:0] ACK_WAITS = `BRI_ACK_WAITS
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [5:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr_stb,
  input wire logic i_rd_stb,
  output logic [7:0] o_rdata,
  input wire logic [14:0] i_ext_req_n,
  input wire logic i_timer_three_output,
  input wire logic i_timer_zero_output,
  input wire logic i_timer_two_output,
  input wire logic i_chain_req,
  input wire logic i_term_cnt_req,
  input wire logic i_cycle_start,
  input wire logic i_mem_io,
  input wire logic i_data_ctl,
  input wire logic i_write_rd,
  output logic [7:0] o_data,
  output logic o_data_oe,
  output logic o_wait_done,
  output logic o_host_maskable_request,
  output logic o_shared_request_three_o,
  output logic o_shared_request_three_oe
);

  bri_state_t s_r;
  bri_state_t s_nxt;

  logic [2:0][8:0] act;
  logic [2:0][8:0] req;
  logic [2:0][8:0] elig;
  logic [2:0] bank_pend;
  logic [1:0] tmr_rise;
  logic [1:0] tmr_clr;
  logic [1:0] tmr_mask;
  logic [2:0][8:0] insrv_w;
  logic [1:0] bank;
  logic [3:0] reg_sel;
  logic [3:0] slot_a;
  logic [3:0] slot_b;
  logic [3:0] slot_c;
  logic [3:0] spec_slot;
  logic ack_seen;
  logic wait_end;

  // bank A carries nine slots: level 1.5 squeezes in between levels 1 and 2,
  // so slot numbers above two are one more than the level number there;
  // banks B and C keep slot equal to level with the top slot unused
  // level number to slot vector; bank A has the 1.5 slot at position two
  function automatic logic [8:0] lvl_to_slot(input logic [1:0] b, input logic [7:0] v);
    if (b == 2'h0) begin
      lvl_to_slot = {v[7:2], 1'b0, v[1:0]};
    end else begin
      lvl_to_slot = {1'b0, v};
    end
  endfunction

  // slot vector back to level numbers
  function automatic logic [7:0] slot_to_lvl(input logic [1:0] b, input logic [8:0] v);
    if (b == 2'h0) begin
      slot_to_lvl = {v[8:3], v[1:0]};
    end else begin
      slot_to_lvl = v[7:0];
    end
  endfunction

  // lowest set index, which is the highest priority
  function automatic logic [3:0] first_set(input logic [8:0] v);
    first_set = 4'h0;
    for (int i = 8; i >= 0; i--) begin
      if (v[i]) begin
        first_set = 4'(i);
      end
    end
  endfunction

  // requests above the highest in-service level, not masked
  function automatic logic [8:0] eligible(input logic [8:0] r, input logic [8:0] m,
                                          input logic [8:0] isv);
    logic stop;
    eligible = 9'h000;
    stop = 1'b0;
    for (int i = 0; i < 9; i++) begin
      stop = stop | isv[i];
      eligible[i] = r[i] & ~m[i] & ~stop;
    end
  endfunction

  // the acknowledge status is only looked at with the cycle-start pulse, so
  // ordinary host reads and writes with the same status lines never match
  // register bus fields
  assign bank = i_addr[`BRI_ADDR_BANK];
  assign reg_sel = i_addr[`BRI_ADDR_REG];
  assign ack_seen = i_cycle_start & ~i_mem_io & ~i_data_ctl & ~i_write_rd;
  assign wait_end = (s_r.wcnt == ACK_WAITS);

  // resolution runs bottom up: bank C feeds bank B slot two, bank B feeds
  // the 1.5 slot of bank A together with any word-two request, so the
  // host request reflects every unmasked level that is not inhibited
  // request sampling, resolution and cascade
  always_comb begin
    act = '0;
    act[0][`BRI_SLOT_SHARED3] = ~i_ext_req_n[0] | i_timer_two_output;
    act[1][1] = ~i_ext_req_n[1];
    act[1][7:3] = ~i_ext_req_n[6:2];
    act[2][7:0] = ~i_ext_req_n[14:7];
    req = s_r.pend;
    req[0][`BRI_SLOT_TIMER] = s_r.tmr_req[0];
    req[0][`BRI_SLOT_CHAIN] = i_chain_req;
    req[0][`BRI_SLOT_TCOUNT] = i_term_cnt_req;
    req[1][`BRI_SLOT_TIMER] = s_r.tmr_req[1];
    elig[2] = eligible(req[2], lvl_to_slot(2'h2, s_r.mask[2]), s_r.insrv[2]);
    bank_pend[2] = |elig[2];
    req[1][`BRI_SLOT_CASC_C] = bank_pend[2];
    elig[1] = eligible(req[1], lvl_to_slot(2'h1, s_r.mask[1]), s_r.insrv[1]);
    bank_pend[1] = |elig[1];
    req[0][`BRI_SLOT_HALF] = bank_pend[1] | (|s_r.init_pend);
    elig[0] = eligible(req[0], lvl_to_slot(2'h0, s_r.mask[0]), s_r.insrv[0]);
    bank_pend[0] = |elig[0];
    slot_a = first_set(elig[0]);
    slot_b = first_set(elig[1]);
    slot_c = first_set(elig[2]);
  end

  // code 8 names the 1.5 slot of bank A; codes at or above two move up by
  // one there; other banks take the code as the slot directly
  // specific level code to slot
  always_comb begin
    spec_slot = i_wdata[`BRI_CMD_LVL];
    if (bank == 2'h0) begin
      if (i_wdata[`BRI_CMD_LVL] == `BRI_LVL_HALF) begin
        spec_slot = `BRI_SLOT_HALF;
      end else if (i_wdata[`BRI_CMD_LVL] >= `BRI_SLOT_HALF) begin
        spec_slot = i_wdata[`BRI_CMD_LVL] + 4'h1;
      end
    end
  end

  // next state
  always_comb begin
    s_nxt = s_r;
    s_nxt.ready = 1'b0;
    s_nxt.rdata = `BRI_RD_NONE;
    insrv_w = s_r.insrv;
    tmr_clr = 2'b00;
    tmr_rise[0] = i_timer_three_output & ~s_r.tmr_prev[0];
    tmr_rise[1] = i_timer_zero_output & ~s_r.tmr_prev[1];
    s_nxt.tmr_prev = {i_timer_zero_output, i_timer_three_output};
    s_nxt.tout_oe = i_timer_two_output;
    s_nxt.int_r = bank_pend[0];

    // edge mode keeps a request until it is acknowledged; level mode drops
    // it as soon as the pin goes high again, so a short pulse can be lost
    // capture external requests per bank mode
    for (int b = 0; b < 3; b++) begin
      s_nxt.prev[b] = act[b];
      if (s_r.lvl_mode[b]) begin
        s_nxt.pend[b] = act[b];
      end else begin
        s_nxt.pend[b] = s_r.pend[b] | (act[b] & ~s_r.prev[b]);
      end
    end

    // writes land at the strobe edge; the unmapped fourth bank is ignored
    // register writes, each bank on its own
    if (i_wr_stb && bank != `BRI_NUM_BANKS) begin
      if (reg_sel == `BRI_REG_WORD1) begin
        s_nxt.lvl_mode[bank] = i_wdata[`BRI_W1_LEVEL];
        s_nxt.auto_end[bank] = i_wdata[`BRI_W1_AUTO];
      end else if (reg_sel == `BRI_REG_WORD2) begin
        s_nxt.word2[bank] = i_wdata;
        s_nxt.init_pend[bank] = 1'b1;
      end else if (reg_sel == `BRI_REG_CASC) begin
        s_nxt.casc[bank] = i_wdata;
      end else if (reg_sel == `BRI_REG_MASK) begin
        s_nxt.mask[bank] = i_wdata;
      end else if (reg_sel == `BRI_REG_CMD) begin
        if (i_wdata[`BRI_CMD_SPEC]) begin
          insrv_w[bank][spec_slot] = 1'b0;
        end else if (|s_r.insrv[bank]) begin
          insrv_w[bank][first_set(s_r.insrv[bank])] = 1'b0;
        end
      end else if (reg_sel == `BRI_REG_VEC15) begin
        if (bank == 2'h0) begin
          s_nxt.vec[0][`BRI_SLOT_HALF] = i_wdata;
        end
      end else if (reg_sel >= `BRI_REG_VEC0) begin
        // only vector offsets store; the status offsets are read only
        s_nxt.vec[bank][first_set(lvl_to_slot(bank, 8'h01 << reg_sel[2:0]))] = i_wdata;
      end
    end

    // read data stand for one cycle only and fall back to zero after it;
    // reading word two is what withdraws that bank's 1.5 request
    // register reads, answered in the next cycle
    if (i_rd_stb && bank != `BRI_NUM_BANKS) begin
      if (reg_sel == `BRI_REG_WORD1) begin
        s_nxt.rdata = {6'h00, s_r.auto_end[bank], s_r.lvl_mode[bank]};
      end else if (reg_sel == `BRI_REG_WORD2) begin
        s_nxt.rdata = s_r.word2[bank];
        s_nxt.init_pend[bank] = 1'b0;
      end else if (reg_sel == `BRI_REG_CASC) begin
        s_nxt.rdata = s_r.casc[bank];
      end else if (reg_sel == `BRI_REG_MASK) begin
        s_nxt.rdata = s_r.mask[bank];
      end else if (reg_sel == `BRI_REG_CMD) begin
        s_nxt.rdata = {5'h00, s_r.served};
      end else if (reg_sel == `BRI_REG_INSRV) begin
        s_nxt.rdata = slot_to_lvl(bank, s_r.insrv[bank]);
      end else if (reg_sel == `BRI_REG_PEND) begin
        s_nxt.rdata = slot_to_lvl(bank, req[bank]);
      end else if (reg_sel == `BRI_REG_VEC15) begin
        s_nxt.rdata = (bank == 2'h0) ? s_r.vec[0][`BRI_SLOT_HALF] : `BRI_RD_NONE;
      end else begin
        s_nxt.rdata = s_r.vec[bank][first_set(lvl_to_slot(bank, 8'h01 << reg_sel[2:0]))];
      end
    end

    // first cycle: resolve, set in-service, hand out the slave level's vector or
    // zero; second cycle: hand out the vector unless a slave answers;
    // the wait counter stretches each cycle by the set number of waits
    // acknowledge sequence
    case (s_r.ack)
      BRI_IDLE: begin
        if (ack_seen) begin
          s_nxt.ack = BRI_ACK1;
          s_nxt.wcnt = 4'h0;
          s_nxt.served = 3'b000;
          s_nxt.data_oe = 1'b1;
          s_nxt.slave = 1'b0;
          if (!bank_pend[0]) begin
            s_nxt.fin_bank = 2'h0;
            s_nxt.fin_slot = `BRI_SLOT_DEFAULT;
          end else begin
            insrv_w[0][slot_a] = 1'b1;
            s_nxt.served[0] = 1'b1;
            s_nxt.fin_bank = 2'h0;
            s_nxt.fin_slot = slot_a;
            if (slot_a == `BRI_SLOT_HALF && !(|s_r.init_pend)) begin
              insrv_w[1][slot_b] = 1'b1;
              s_nxt.served[1] = 1'b1;
              s_nxt.fin_bank = 2'h1;
              s_nxt.fin_slot = slot_b;
              if (slot_b == `BRI_SLOT_CASC_C) begin
                insrv_w[2][slot_c] = 1'b1;
                s_nxt.served[2] = 1'b1;
                s_nxt.fin_bank = 2'h2;
                s_nxt.fin_slot = slot_c;
              end
            end
          end
          // a slave level's vector replaces the zero byte only for a real request
          s_nxt.data = `BRI_NO_SLAVE_BYTE;
          if (bank_pend[0] && s_nxt.fin_slot != `BRI_SLOT_HALF &&
              lvl_to_slot(s_nxt.fin_bank, s_r.casc[s_nxt.fin_bank])[s_nxt.fin_slot]) begin
            s_nxt.slave = 1'b1;
            s_nxt.data = s_r.vec[s_nxt.fin_bank][s_nxt.fin_slot];
          end
          if (bank_pend[0]) begin
            s_nxt.pend[s_nxt.fin_bank][s_nxt.fin_slot] = 1'b0;
            if (s_nxt.fin_slot == `BRI_SLOT_TIMER && s_nxt.fin_bank != 2'h2) begin
              tmr_clr[s_nxt.fin_bank[0]] = 1'b1;
            end
          end
        end
      end
      BRI_ACK1: begin
        s_nxt.wcnt = s_r.wcnt + 4'h1;
        if (wait_end) begin
          s_nxt.ready = 1'b1;
          s_nxt.data_oe = 1'b0;
          s_nxt.ack = BRI_GAP;
        end
      end
      // host idle states pass here; any number of them is accepted
      BRI_GAP: begin
        if (ack_seen) begin
          s_nxt.ack = BRI_ACK2;
          s_nxt.wcnt = 4'h0;
          s_nxt.data = s_r.vec[s_r.fin_bank][s_r.fin_slot];
          s_nxt.data_oe = ~s_r.slave;
        end
      end
      BRI_ACK2: begin
        s_nxt.wcnt = s_r.wcnt + 4'h1;
        if (wait_end) begin
          s_nxt.ready = 1'b1;
          s_nxt.data_oe = 1'b0;
          s_nxt.ack = BRI_IDLE;
          // automatic end acts only on banks served by this acknowledge
          for (int b = 0; b < 3; b++) begin
            if (s_r.served[b] && s_r.auto_end[b] && |insrv_w[b]) begin
              insrv_w[b][first_set(insrv_w[b])] = 1'b0;
            end
          end
        end
      end
      default: begin
        s_nxt.ack = BRI_IDLE;
      end
    endcase
    s_nxt.insrv = insrv_w;

    // the level 0 mask bit of banks A and B also empties that bank's timer latch, so
    // an edge that arrives while masked is dropped rather than held
    // timer latches: a new edge beats the acknowledge clear, mask clears
    tmr_mask[0] = s_r.mask[0][0];
    tmr_mask[1] = s_r.mask[1][0];
    s_nxt.tmr_req = ((s_r.tmr_req & ~tmr_clr) | tmr_rise) & ~tmr_mask;
  end

  // reset empties every pending, in-service and timer latch bit and
  // returns all banks to edge mode with no automatic end
  // state register
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // the shared pin is open drain: its drive value is always low and only
  // the enable follows timer two, a cycle late
  // outputs straight from the state
  assign o_rdata = s_r.rdata;
  assign o_data = s_r.data;
  assign o_data_oe = s_r.data_oe;
  assign o_wait_done = s_r.ready;
  assign o_host_maskable_request = s_r.int_r;
  assign o_shared_request_three_o = 1'b0;
  assign o_shared_request_three_oe = s_r.tout_oe;

endmodule // bri_banked_request
`default_nettype wire

// ===== core/bri_regs.svh
// register offsets, field positions, slot numbers, fixed values and counts of the banked request block
// assumes inclusion by the block itself
`ifndef BRI_REGS_SVH
`define BRI_REGS_SVH
// address split: bank in the upper two bits, register in the lower four
`define BRI_ADDR_BANK 5:4
`define BRI_ADDR_REG 3:0
`define BRI_NUM_BANKS 2'h3
// register offsets within one bank
`define BRI_REG_WORD1 4'h0
`define BRI_REG_WORD2 4'h1
`define BRI_REG_CASC 4'h2
`define BRI_REG_MASK 4'h3
`define BRI_REG_CMD 4'h4
`define BRI_REG_INSRV 4'h5
`define BRI_REG_PEND 4'h6
`define BRI_REG_VEC15 4'h7
`define BRI_REG_VEC0 4'h8
// init_word_one fields
`define BRI_W1_LEVEL 0
`define BRI_W1_AUTO 1
// end_of_service_command fields
`define BRI_CMD_SPEC 4
`define BRI_CMD_LVL 3:0
`define BRI_LVL_HALF 4'h8
// slot numbers; a lower slot number is a higher priority
`define BRI_SLOT_HALF 4'h2
`define BRI_SLOT_CASC_C 4'h2
`define BRI_SLOT_DEFAULT 4'h8
`define BRI_SLOT_TIMER 4'h0
`define BRI_SLOT_CHAIN 4'h1
`define BRI_SLOT_SHARED3 4'h4
`define BRI_SLOT_TCOUNT 4'h5
// values
`define BRI_NO_SLAVE_BYTE 8'h00
`define BRI_RD_NONE 8'h00
`define BRI_ACK_WAITS 4'h2
`endif

// ===== core/bri_pkg.sv
// types of the banked request block
// assumes bri_regs.svh sits beside it
`default_nettype none
package bri_pkg;
  // acknowledge sequence
  typedef enum logic [1:0] {
    BRI_IDLE = 2'b00,
    BRI_ACK1 = 2'b01,
    BRI_GAP  = 2'b10,
    BRI_ACK2 = 2'b11
  } bri_ack_t;

  // whole state of the block
  typedef struct packed {
    bri_ack_t ack;
    logic [3:0] wcnt;
    logic [2:0][8:0] pend;
    logic [2:0][8:0] insrv;
    logic [2:0][8:0] prev;
    logic [2:0][7:0] mask;
    logic [2:0][7:0] casc;
    logic [2:0][7:0] word2;
    logic [2:0] lvl_mode;
    logic [2:0] auto_end;
    logic [2:0] init_pend;
    logic [2:0][8:0][7:0] vec;
    logic [1:0] tmr_prev;
    logic [1:0] tmr_req;
    logic [2:0] served;
    logic [1:0] fin_bank;
    logic [3:0] fin_slot;
    logic slave;
    logic int_r;
    logic [7:0] rdata;
    logic [7:0] data;
    logic data_oe;
    logic ready;
    logic tout_oe;
  } bri_state_t;
endpackage
`default_nettype wire

// ===== test/bri_monitor.sv
// checker of the banked request block, sees only its ports
// assumes the same wait count parameter as the block it watches
`default_nettype none
module bri_monitor
  import bri_pkg::*;
#(
  parameter logic [3:0] ACK_WAITS = 4'h2
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_rd_stb,
  input wire logic i_cycle_start,
  input wire logic i_mem_io,
  input wire logic i_data_ctl,
  input wire logic i_write_rd,
  input wire logic i_timer_two_output,
  input wire logic [7:0] o_rdata,
  input wire logic [7:0] o_data,
  input wire logic o_data_oe,
  input wire logic o_wait_done,
  input wire logic o_shared_request_three_o,
  input wire logic o_shared_request_three_oe
);
  logic [4:0] oe_len_r;
  // cycles the acknowledge byte has stood so far
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      oe_len_r <= 5'h00;
    end else begin
      oe_len_r <= o_data_oe ? oe_len_r + 5'h01 : 5'h00;
    end
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  a_ack_start_cause: assert property ($rose(o_data_oe) |->
    $past(i_cycle_start && !i_mem_io && !i_data_ctl && !i_write_rd)) else $error("drive w/o ack");
  a_ack_wait_len: assert property ($fell(o_data_oe) |->
    o_wait_done && oe_len_r == {1'h0, ACK_WAITS} + 5'h01) else $error("wait count off");
  a_wait_single: assert property (o_wait_done |=> !o_wait_done)
    else $error("wait pulse too long");
  a_wait_no_drive: assert property (o_wait_done |-> !o_data_oe)
    else $error("bus still driven");
  a_vector_steady: assert property (o_data_oe && $past(o_data_oe) |-> $stable(o_data))
    else $error("byte changed");
  a_pin_follows_timer: assert property (o_shared_request_three_oe == $past(i_timer_two_output))
    else $error("shared pin drive wrong");
  a_pin_open_drain: assert property (!o_shared_request_three_o)
    else $error("shared pin driven high");
  a_read_quiet: assert property (!$past(i_rd_stb) |-> o_rdata == 8'h00)
    else $error("read data outside slot");
endmodule // bri_monitor
bind bri_banked_request bri_monitor #(.ACK_WAITS(ACK_WAITS)) u_mon (.i_clk, .i_rst, .i_rd_stb,
  .i_cycle_start, .i_mem_io, .i_data_ctl, .i_write_rd, .i_timer_two_output, .o_rdata, .o_data,
  .o_data_oe, .o_wait_done, .o_shared_request_three_o, .o_shared_request_three_oe);
`default_nettype wire

// ===== test/bri_host_model.sv
// host side of the acknowledge handshake: two acknowledge cycles per go pulse
// assumes the block ends each cycle with a one-cycle wait-done pulse
`default_nettype none
module bri_host_model (
  input wire logic i_clk,
  input wire logic i_go,
  input wire logic [7:0] i_data,
  input wire logic i_data_oe,
  input wire logic i_wait_done,
  output logic o_cycle_start,
  output logic o_mem_io,
  output logic o_data_ctl,
  output logic o_write_rd,
  output logic o_done,
  output logic [7:0] o_byte1,
  output logic [7:0] o_byte2,
  output logic o_oe1,
  output logic o_oe2
);
  timeunit 1ns;
  timeprecision 1ps;
  // one cycle: start pulse with all status low, then collect the byte
  task automatic ack_cycle(output logic [7:0] b, output logic oe);
    int n;
    b = 8'h00;
    oe = 1'h0;
    o_cycle_start <= 1'h1;
    {o_mem_io, o_data_ctl, o_write_rd} <= 3'h0;
    @(posedge i_clk);
    o_cycle_start <= 1'h0;
    {o_mem_io, o_data_ctl, o_write_rd} <= 3'h7;
    for (n = 0; n < 40 && i_wait_done !== 1'h1; n++) begin
      @(posedge i_clk);
      if (i_data_oe === 1'h1) begin
        b = i_data;
        oe = 1'h1;
      end
    end
  endtask
  // on go: both cycles, four idle states between
  initial begin
    o_cycle_start = 1'h0;
    {o_mem_io, o_data_ctl, o_write_rd} = 3'h7;
    {o_done, o_oe1, o_oe2} = 3'h0;
    o_byte1 = 8'h00;
    o_byte2 = 8'h00;
    forever begin
      @(posedge i_clk);
      o_done <= 1'h0;
      if (i_go === 1'h1) begin
        ack_cycle(o_byte1, o_oe1);
        repeat (4) @(posedge i_clk);
        ack_cycle(o_byte2, o_oe2);
        o_done <= 1'h1;
      end
    end
  end
endmodule // bri_host_model
`default_nettype wire

// ===== test/tb.sv
// bench of the banked request block with a host model on the acknowledge side
// assumes default wait count and a 40 MHz clock
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clk = 1'h0, i_rst = 1'h1, i_wr_stb = 1'h0, i_rd_stb = 1'h0, go = 1'h0;
  logic [5:0] i_addr = 6'h00;
  logic [7:0] i_wdata = 8'h00, o_rdata, o_data, b1, b2;
  logic [14:0] i_ext_req_n = 15'h7FFF;
  logic t3 = 1'h0, t0 = 1'h0, t2 = 1'h0, chain = 1'h0, tcnt = 1'h0;
  logic cs, mio, dc, wr_n, o_data_oe, o_wait_done, o_host_maskable_request, pin_o, pin_oe;
  logic done, oe1, oe2;
  int fail_count = 0, compares = 0;
  always #12.5 i_clk = ~i_clk;
  bri_banked_request uut (.i_clk, .i_rst, .i_addr, .i_wdata, .i_wr_stb, .i_rd_stb, .o_rdata,
    .i_ext_req_n, .i_timer_three_output(t3), .i_timer_zero_output(t0), .i_timer_two_output(t2),
    .i_chain_req(chain), .i_term_cnt_req(tcnt), .i_cycle_start(cs), .i_mem_io(mio),
    .i_data_ctl(dc), .i_write_rd(wr_n), .o_data, .o_data_oe, .o_wait_done,
    .o_host_maskable_request, .o_shared_request_three_o(pin_o),
    .o_shared_request_three_oe(pin_oe));
  bri_host_model host (.i_clk, .i_go(go), .i_data(o_data), .i_data_oe(o_data_oe),
    .i_wait_done(o_wait_done), .o_cycle_start(cs), .o_mem_io(mio), .o_data_ctl(dc),
    .o_write_rd(wr_n), .o_done(done), .o_byte1(b1), .o_byte2(b2), .o_oe1(oe1), .o_oe2(oe2));
  task automatic end_sim();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("Error %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    i_addr <= a;
    i_wdata <= d;
    i_wr_stb <= 1'h1;
    @(posedge i_clk);
    i_wr_stb <= 1'h0;
    @(posedge i_clk);
  endtask
  task automatic rd(input logic [5:0] a, input logic [7:0] exp);
    i_addr <= a;
    i_rd_stb <= 1'h1;
    @(posedge i_clk);
    i_rd_stb <= 1'h0;
    #1 chk(o_rdata, exp);
    @(posedge i_clk);
  endtask
  task automatic hreq(input logic e);
    int n;
    for (n = 0; n < 20 && o_host_maskable_request !== e; n++) @(posedge i_clk);
    chk({7'h00, o_host_maskable_request}, {7'h00, e});
    if (n == 20) end_sim();
  endtask
  task automatic ack(input logic [7:0] e1, input logic eo1, input logic [7:0] e2, input logic eo2);
    int n;
    go <= 1'h1;
    @(posedge i_clk);
    go <= 1'h0;
    for (n = 0; n < 200 && done !== 1'h1; n++) @(posedge i_clk);
    if (n == 200) begin
      fail_count++;
      end_sim();
    end
    chk(b1, e1);
    chk({7'h00, oe1}, {7'h00, eo1});
    chk(b2, e2);
    chk({7'h00, oe2}, {7'h00, eo2});
  endtask
  // reset values, unmapped bank, default vector
  task automatic t_reset_default();
    rd(6'h03, 8'h00);
    wr(6'h33, 8'hFF);
    rd(6'h33, 8'h00);
    hreq(1'h0);
    wr(6'h0F, 8'h7A);
    ack(8'h00, 1'h1, 8'h7A, 1'h1);
    rd(6'h05, 8'h00);
  endtask
  // external edge request, then non-specific end
  task automatic t_ext();
    wr(6'h0B, 8'h33);
    i_ext_req_n[0] <= 1'h0;
    hreq(1'h1);
    ack(8'h00, 1'h1, 8'h33, 1'h1);
    i_ext_req_n[0] <= 1'h1;
    rd(6'h05, 8'h08);
    wr(6'h04, 8'h00);
    rd(6'h05, 8'h00);
  endtask
  // nesting, masking and specific end on the DMA levels
  task automatic t_nest();
    wr(6'h09, 8'h11);
    wr(6'h0C, 8'h44);
    chain <= 1'h1;
    tcnt <= 1'h1;
    hreq(1'h1);
    ack(8'h00, 1'h1, 8'h11, 1'h1);
    chain <= 1'h0;
    hreq(1'h0);
    wr(6'h03, 8'h10);
    wr(6'h04, 8'h11);
    rd(6'h05, 8'h00);
    hreq(1'h0);
    wr(6'h03, 8'h00);
    hreq(1'h1);
    ack(8'h00, 1'h1, 8'h44, 1'h1);
    tcnt <= 1'h0;
    wr(6'h04, 8'h00);
    rd(6'h05, 8'h00);
  endtask
  // timer latch with automatic end, and clearing by mask
  task automatic t_timer();
    wr(6'h00, 8'h02);
    wr(6'h08, 8'h0A);
    t3 <= 1'h1;
    hreq(1'h1);
    ack(8'h00, 1'h1, 8'h0A, 1'h1);
    rd(6'h05, 8'h00);
    hreq(1'h0);
    t3 <= 1'h0;
    wr(6'h03, 8'h01);
    t3 <= 1'h1;
    wr(6'h03, 8'h00);
    t3 <= 1'h0;
    hreq(1'h0);
    wr(6'h00, 8'h00);
  endtask
  // bank C request with an external slave
  task automatic t_slave();
    wr(6'h22, 8'h01);
    wr(6'h28, 8'h5C);
    i_ext_req_n[7] <= 1'h0;
    hreq(1'h1);
    ack(8'h5C, 1'h1, 8'h00, 1'h0);
    i_ext_req_n[7] <= 1'h1;
    wr(6'h24, 8'h00);
    wr(6'h14, 8'h00);
    wr(6'h04, 8'h00);
    rd(6'h25, 8'h00);
    rd(6'h05, 8'h00);
  endtask
  // word two write beats the bank B cascade until read back
  task automatic t_init();
    wr(6'h07, 8'h15);
    wr(6'h19, 8'h91);
    wr(6'h11, 8'hB2);
    i_ext_req_n[1] <= 1'h0;
    ack(8'h00, 1'h1, 8'h15, 1'h1);
    wr(6'h04, 8'h18);
    rd(6'h11, 8'hB2);
    ack(8'h00, 1'h1, 8'h91, 1'h1);
    i_ext_req_n[1] <= 1'h1;
    wr(6'h14, 8'h00);
    wr(6'h04, 8'h00);
    rd(6'h05, 8'h00);
  endtask
  // timer two pulls the shared pin and requests level 3
  task automatic t_shared();
    t2 <= 1'h1;
    hreq(1'h1);
    chk({7'h00, pin_oe}, 8'h01);
    ack(8'h00, 1'h1, 8'h33, 1'h1);
    t2 <= 1'h0;
    wr(6'h04, 8'h00);
    rd(6'h05, 8'h00);
  endtask
  // main sequence
  initial begin
    repeat (10) @(posedge i_clk);
    i_rst <= 1'h0;
    @(posedge i_clk);
    t_reset_default();
    t_ext();
    t_nest();
    t_timer();
    t_slave();
    t_init();
    t_shared();
    end_sim();
  end
endmodule // tb
`default_nettype wire
